// ==== hdl/tse_pkg.sv ====
package tse_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] TSE_CTRL_OFS     = 8'h00;
  localparam logic [7:0] TSE_ENABLE_OFS   = 8'h0c;
  localparam logic [7:0] TSE_STATUS_OFS   = 8'h10;
  localparam logic [7:0] TSE_EVGEN_OFS    = 8'h14;
  localparam logic [7:0] TSE_CHMODE_OFS   = 8'h18;
  localparam logic [7:0] TSE_COUNT_OFS    = 8'h24;
  localparam logic [7:0] TSE_PRESC_OFS    = 8'h28;
  localparam logic [7:0] TSE_RELOAD_OFS   = 8'h2c;
  localparam logic [7:0] TSE_CH1_OFS      = 8'h34;
  localparam logic [7:0] TSE_IRQ_STAT_OFS = 8'h40;
  localparam logic [7:0] TSE_IRQ_MASK_OFS = 8'h44;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int TSE_CTRL_EN_BIT      = 0;
  localparam int TSE_CTRL_INHIBIT_BIT = 1;
  localparam int TSE_CTRL_SRC_BIT     = 2;
  localparam int TSE_CTRL_MODE_LSB    = 4;
  localparam int TSE_EN_UIE_BIT       = 0;
  localparam int TSE_EN_CH1IE_BIT     = 1;
  localparam int TSE_EN_UDE_BIT       = 8;
  localparam int TSE_EN_CH1DE_BIT     = 9;
  localparam int TSE_ST_UPD_BIT       = 0;
  localparam int TSE_ST_CH1_BIT       = 1;
  localparam int TSE_ST_OVC_BIT       = 9;
  localparam int TSE_EG_UPD_BIT       = 0;
  localparam int TSE_EG_CH1_BIT       = 1;
  localparam int TSE_CHM_SEL_LSB      = 0;
  localparam int TSE_IRQ_UPD_BIT      = 0;
  localparam int TSE_IRQ_CH1_BIT      = 1;
  localparam int TSE_IRQ_OVC_BIT      = 2;

  // ---------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------
  localparam int          TSE_CNT_W      = 16;
  localparam int          TSE_IRQ_W      = 3;
  localparam logic [15:0] TSE_CNT_RST    = 16'h0000;
  localparam logic [15:0] TSE_PRESC_RST  = 16'h0000;
  localparam logic [15:0] TSE_RELOAD_RST = 16'hffff;
  localparam logic [15:0] TSE_CH1_RST    = 16'h0000;
  localparam logic [2:0]  TSE_IRQ_RST    = 3'h0;

  typedef enum logic [1:0] {
    TSE_CNT_UP,
    TSE_CNT_DOWN,
    TSE_CNT_CENTRE,
    TSE_CNT_HOLD
  } tse_cnt_mode_t;

  typedef struct packed {
    logic          counter_enable;
    logic          update_inhibit;
    logic          update_source_select;
    tse_cnt_mode_t mode;
  } tse_ctrl_t;

  typedef struct packed {
    logic ude;
    logic ch1_dma_enable;
    logic update_irq_enable;
    logic ch1_irq_enable;
  } tse_enable_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       write;
  } tse_aphase_t;

  typedef enum logic [1:0] {
    TSE_BUS_IDLE,
    TSE_BUS_WRITE,
    TSE_BUS_READ_WAIT,
    TSE_BUS_READ_DATA
  } tse_bus_state_t;

endpackage

// ==== hdl/tse_timer_status.sv ====
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module tse_timer_status
  import tse_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        capture_pulse,
  input  wire logic        trigger_reinit,
  output logic [15:0]      counter_value,
  output logic             update_event,
  output logic             update_irq_req,
  output logic             ch1_irq_req,
  output logic             update_dma_req,
  output logic             ch1_dma_req,
  output logic             irq
);

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  // Set wins over clear so an event in the clearing cycle is kept.
  function automatic logic flag_next(input logic q, input logic set, input logic clr);
    flag_next = set | (q & ~clr);
  endfunction

  // -----------------------------------------------------------------
  // AHB-Lite slave
  // -----------------------------------------------------------------
  tse_bus_state_t bus_q;
  tse_bus_state_t bus_d;
  tse_aphase_t    aph_q;
  logic [31:0]    hrdata_q;
  logic [31:0]    rdata;

  wire accept  = hsel & htrans[1] & hready;
  wire wr_en   = (bus_q == TSE_BUS_WRITE);
  wire rd_fire = (bus_q == TSE_BUS_READ_WAIT);

  // Reads take one wait state so the returned word includes any write just before it.
  assign hreadyout = (bus_q != TSE_BUS_READ_WAIT);
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  always_comb begin
    bus_d = TSE_BUS_IDLE;
    case (bus_q)
      TSE_BUS_READ_WAIT: begin
        bus_d = TSE_BUS_READ_DATA;
      end
      default: begin
        if (accept) begin
          bus_d = hwrite ? TSE_BUS_WRITE : TSE_BUS_READ_WAIT;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bus_q <= TSE_BUS_IDLE;
      aph_q <= '0;
    end else begin
      bus_q <= bus_d;
      if (accept && hreadyout) begin
        aph_q <= '{addr: haddr[7:0], write: hwrite};
      end
    end
  end

  wire wr_ctrl   = wr_en && (aph_q.addr == TSE_CTRL_OFS);
  wire wr_enable = wr_en && (aph_q.addr == TSE_ENABLE_OFS);
  wire wr_status = wr_en && (aph_q.addr == TSE_STATUS_OFS);
  wire wr_evgen  = wr_en && (aph_q.addr == TSE_EVGEN_OFS);
  wire wr_chmode = wr_en && (aph_q.addr == TSE_CHMODE_OFS);
  wire wr_count  = wr_en && (aph_q.addr == TSE_COUNT_OFS);
  wire wr_presc  = wr_en && (aph_q.addr == TSE_PRESC_OFS);
  wire wr_reload = wr_en && (aph_q.addr == TSE_RELOAD_OFS);
  wire wr_ch1    = wr_en && (aph_q.addr == TSE_CH1_OFS);
  wire wr_mask   = wr_en && (aph_q.addr == TSE_IRQ_MASK_OFS);
  wire rd_ch1    = rd_fire && (aph_q.addr == TSE_CH1_OFS);
  wire rd_irq    = rd_fire && (aph_q.addr == TSE_IRQ_STAT_OFS);

  // -----------------------------------------------------------------
  // Configuration registers
  // -----------------------------------------------------------------
  tse_ctrl_t      ctrl_q;
  tse_enable_t    en_q;
  logic [1:0]     chsel_q;
  logic [15:0]    presc_q;
  logic [15:0]    reload_q;
  logic [TSE_IRQ_W-1:0] irq_mask_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_q     <= '{counter_enable: 1'b0, update_inhibit: 1'b0,
                      update_source_select: 1'b0, mode: TSE_CNT_UP};
      en_q       <= '0;
      chsel_q    <= 2'h0;
      presc_q    <= TSE_PRESC_RST;
      reload_q   <= TSE_RELOAD_RST;
      irq_mask_q <= TSE_IRQ_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= '{counter_enable:       hwdata[TSE_CTRL_EN_BIT],
                    update_inhibit:       hwdata[TSE_CTRL_INHIBIT_BIT],
                    update_source_select: hwdata[TSE_CTRL_SRC_BIT],
                    mode: tse_cnt_mode_t'(hwdata[TSE_CTRL_MODE_LSB +: 2])};
      end
      if (wr_enable) begin
        en_q <= '{ude:               hwdata[TSE_EN_UDE_BIT],
                  ch1_dma_enable:    hwdata[TSE_EN_CH1DE_BIT],
                  update_irq_enable: hwdata[TSE_EN_UIE_BIT],
                  ch1_irq_enable:    hwdata[TSE_EN_CH1IE_BIT]};
      end
      if (wr_chmode) begin
        chsel_q <= hwdata[TSE_CHM_SEL_LSB +: 2];
      end
      if (wr_presc) begin
        presc_q <= hwdata[15:0];
      end
      if (wr_reload) begin
        reload_q <= hwdata[15:0];
      end
      if (wr_mask) begin
        irq_mask_q <= hwdata[TSE_IRQ_W-1:0];
      end
    end
  end

  wire in_mode  = (chsel_q != 2'h0);
  wire out_mode = ~in_mode;

  // -----------------------------------------------------------------
  // Software events
  // -----------------------------------------------------------------
  // Force bits are never stored: a written one is a single-cycle pulse, so they
  // read back as zero and a written zero has no effect.
  wire force_upd = wr_evgen & hwdata[TSE_EG_UPD_BIT];
  wire force_ch1 = wr_evgen & hwdata[TSE_EG_CH1_BIT];

  // -----------------------------------------------------------------
  // Prescaler and counter
  // -----------------------------------------------------------------
  logic [15:0] psc_cnt_q;
  logic [15:0] cnt_q;
  logic [15:0] cnt_adv;
  logic        dir_down_q;
  logic        dir_down_adv;
  logic        wrap;

  wire tick   = ctrl_q.counter_enable & (psc_cnt_q == presc_q);
  wire reinit = force_upd | trigger_reinit;
  wire ovf    = tick & wrap;

  always_comb begin
    cnt_adv      = cnt_q;
    dir_down_adv = dir_down_q;
    wrap         = 1'b0;
    case (ctrl_q.mode)
      TSE_CNT_UP: begin
        wrap    = (cnt_q == reload_q);
        cnt_adv = wrap ? TSE_CNT_RST : cnt_q + 16'h0001;
      end
      TSE_CNT_DOWN: begin
        wrap    = (cnt_q == 16'h0000);
        cnt_adv = wrap ? reload_q : cnt_q - 16'h0001;
      end
      TSE_CNT_CENTRE: begin
        if (!dir_down_q) begin
          wrap         = (cnt_q >= reload_q);
          dir_down_adv = wrap;
          cnt_adv      = wrap ? ((cnt_q == 16'h0000) ? cnt_q : cnt_q - 16'h0001)
                              : cnt_q + 16'h0001;
        end else begin
          wrap         = (cnt_q == 16'h0000);
          dir_down_adv = ~wrap;
          cnt_adv      = wrap ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
        end
      end
      default: begin
        cnt_adv = cnt_q;
      end
    endcase
  end

  // Inhibit masks every source; source select narrows only the flag and requests.
  wire uev     = ~ctrl_q.update_inhibit & (ovf | reinit);
  wire upd_set = ~ctrl_q.update_inhibit &
                 (ovf | (~ctrl_q.update_source_select & reinit));

  wire [15:0] cnt_init = (ctrl_q.mode == TSE_CNT_DOWN) ? reload_q : TSE_CNT_RST;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      psc_cnt_q  <= 16'h0000;
      cnt_q      <= TSE_CNT_RST;
      dir_down_q <= 1'b0;
    end else begin
      if (reinit || uev || tick) begin
        psc_cnt_q <= 16'h0000;
      end else if (ctrl_q.counter_enable) begin
        psc_cnt_q <= psc_cnt_q + 16'h0001;
      end
      if (wr_count) begin
        cnt_q <= hwdata[15:0];
      end else if (reinit) begin
        cnt_q      <= cnt_init;
        dir_down_q <= 1'b0;
      end else if (tick) begin
        cnt_q      <= cnt_adv;
        dir_down_q <= dir_down_adv;
      end
    end
  end

  // -----------------------------------------------------------------
  // Channel 1 compare and capture
  // -----------------------------------------------------------------
  logic [15:0] ch1_q;
  logic        upd_flag_q;
  logic        ch1_flag_q;
  logic        ovc_flag_q;

  wire cmp_hit = out_mode & tick & ~reinit & (cnt_adv == ch1_q);
  wire cap_now = in_mode & (capture_pulse | force_ch1);
  wire ch1_set = cmp_hit | (out_mode & force_ch1) | cap_now;
  wire ovc_set = cap_now & ch1_flag_q;

  // A write of one keeps the flag; a written zero clears it, and a read of the channel 1 register also clears the channel 1 flag.
  wire upd_clr = wr_status & ~hwdata[TSE_ST_UPD_BIT];
  wire ch1_clr = (wr_status & ~hwdata[TSE_ST_CH1_BIT]) | rd_ch1;
  wire ovc_clr = wr_status & ~hwdata[TSE_ST_OVC_BIT];

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ch1_q      <= TSE_CH1_RST;
      upd_flag_q <= 1'b0;
      ch1_flag_q <= 1'b0;
      ovc_flag_q <= 1'b0;
    end else begin
      if (cap_now) begin
        ch1_q <= cnt_q;
      end else if (wr_ch1 && out_mode) begin
        ch1_q <= hwdata[15:0];
      end
      upd_flag_q <= flag_next(upd_flag_q, upd_set, upd_clr);
      ch1_flag_q <= flag_next(ch1_flag_q, ch1_set, ch1_clr);
      ovc_flag_q <= flag_next(ovc_flag_q, ovc_set, ovc_clr);
    end
  end

  // -----------------------------------------------------------------
  // Requests and interrupt summary
  // -----------------------------------------------------------------
  logic [TSE_IRQ_W-1:0] irq_stat_q;
  logic                 uev_q;
  logic                 upd_dma_q;
  logic                 ch1_dma_q;
  wire  [TSE_IRQ_W-1:0] irq_evt = {ovc_set, ch1_set, upd_set};

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_stat_q <= TSE_IRQ_RST;
      uev_q      <= 1'b0;
      upd_dma_q  <= 1'b0;
      ch1_dma_q  <= 1'b0;
    end else begin
      irq_stat_q <= irq_evt | (irq_stat_q & {TSE_IRQ_W{~rd_irq}});
      uev_q      <= uev;
      upd_dma_q  <= upd_set & en_q.ude;
      ch1_dma_q  <= ch1_set & en_q.ch1_dma_enable;
    end
  end

  assign counter_value  = cnt_q;
  assign update_event   = uev_q;
  assign update_irq_req = en_q.update_irq_enable & upd_flag_q;
  assign ch1_irq_req    = en_q.ch1_irq_enable & ch1_flag_q;
  assign update_dma_req = upd_dma_q;
  assign ch1_dma_req    = ch1_dma_q;
  assign irq            = |(irq_stat_q & irq_mask_q);

  // -----------------------------------------------------------------
  // Read mux
  // -----------------------------------------------------------------
  always_comb begin
    rdata = 32'h0000_0000;
    if (aph_q.addr == TSE_CTRL_OFS) begin
      rdata[TSE_CTRL_EN_BIT]         = ctrl_q.counter_enable;
      rdata[TSE_CTRL_INHIBIT_BIT]    = ctrl_q.update_inhibit;
      rdata[TSE_CTRL_SRC_BIT]        = ctrl_q.update_source_select;
      rdata[TSE_CTRL_MODE_LSB +: 2]  = ctrl_q.mode;
    end else if (aph_q.addr == TSE_ENABLE_OFS) begin
      rdata[TSE_EN_UIE_BIT]   = en_q.update_irq_enable;
      rdata[TSE_EN_CH1IE_BIT] = en_q.ch1_irq_enable;
      rdata[TSE_EN_UDE_BIT]   = en_q.ude;
      rdata[TSE_EN_CH1DE_BIT] = en_q.ch1_dma_enable;
    end else if (aph_q.addr == TSE_STATUS_OFS) begin
      rdata[TSE_ST_UPD_BIT] = upd_flag_q;
      rdata[TSE_ST_CH1_BIT] = ch1_flag_q;
      rdata[TSE_ST_OVC_BIT] = ovc_flag_q;
    end else if (aph_q.addr == TSE_CHMODE_OFS) begin
      rdata[TSE_CHM_SEL_LSB +: 2] = chsel_q;
    end else if (aph_q.addr == TSE_COUNT_OFS) begin
      rdata[15:0] = cnt_q;
    end else if (aph_q.addr == TSE_PRESC_OFS) begin
      rdata[15:0] = presc_q;
    end else if (aph_q.addr == TSE_RELOAD_OFS) begin
      rdata[15:0] = reload_q;
    end else if (aph_q.addr == TSE_CH1_OFS) begin
      rdata[15:0] = ch1_q;
    end else if (aph_q.addr == TSE_IRQ_STAT_OFS) begin
      rdata[TSE_IRQ_W-1:0] = irq_stat_q;
    end else if (aph_q.addr == TSE_IRQ_MASK_OFS) begin
      rdata[TSE_IRQ_W-1:0] = irq_mask_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_fire) begin
      hrdata_q <= rdata;
    end
  end

endmodule

`default_nettype wire

// ==== test/tb_tse_timer_status.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_tse_timer_status;
  import tse_pkg::*;
  logic        core_clk, sys_rst, hsel, hwrite, capture_pulse, trigger_reinit;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, update_event, update_irq_req, ch1_irq_req;
  logic        update_dma_req, ch1_dma_req, irq;
  logic [15:0] counter_value;
  int          error_cnt, n_checks, dma_n, udma_n, i;

  // Bus hready is the slave's own hreadyout, as there is only one slave.
  tse_timer_status DUT (.core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .capture_pulse(capture_pulse),
    .trigger_reinit(trigger_reinit), .counter_value(counter_value),
    .update_event(update_event), .update_irq_req(update_irq_req), .ch1_irq_req(ch1_irq_req),
    .update_dma_req(update_dma_req), .ch1_dma_req(ch1_dma_req), .irq(irq));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (ch1_dma_req === 1'b1) dma_n <= dma_n + 1;
    if (update_dma_req === 1'b1) udma_n <= udma_n + 1;
  end

  // ---------------------------------------------------------------
  // Bus and checking tasks
  // ---------------------------------------------------------------
  task check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    r = hrdata;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task rdc(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(n, r & m, e);
  endtask

  task pulse(input logic c, input logic t);
    @(posedge core_clk);
    capture_pulse <= c;
    trigger_reinit <= t;
    @(posedge core_clk);
    capture_pulse <= 1'b0;
    trigger_reinit <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask

  task results;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    results;
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    {hsel, hwrite, capture_pulse, trigger_reinit, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    sys_rst = 1'b1;
    error_cnt = 0;
    n_checks = 0;
    dma_n = 0;
    udma_n = 0;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    rdc("status reset", TSE_STATUS_OFS, 32'hffff_ffff, 32'h0);
    check("okay resp", {31'h0, hresp}, 32'h0);
    rdc("evgen reset", TSE_EVGEN_OFS, 32'hffff_ffff, 32'h0);
    rdc("reload reset", TSE_RELOAD_OFS, 32'hffff_ffff, 32'h0000_ffff);
    wr(8'h08, 32'h1234);
    rdc("unmapped", 8'h08, 32'hffff_ffff, 32'h0);
    wr(TSE_STATUS_OFS, 32'hffff_ffff);
    rdc("status ones", TSE_STATUS_OFS, 32'hffff_ffff, 32'h0);
    $display("reset test done");
    wr(TSE_RELOAD_OFS, 32'h55);
    wr(TSE_PRESC_OFS, 32'h5);
    for (i = 0; i < 3; i++) begin
      wr(TSE_CTRL_OFS, {26'h0, i[1:0], 4'h0});
      wr(TSE_COUNT_OFS, 32'h33);
      wr(TSE_EVGEN_OFS, 32'h0);
      rdc("zero write", TSE_COUNT_OFS, 32'hffff, 32'h33);
      wr(TSE_EVGEN_OFS, 32'h1);
      rdc("reinit count", TSE_COUNT_OFS, 32'hffff, (i == 1) ? 32'h55 : 32'h0);
      check("count pin", {16'h0, counter_value}, (i == 1) ? 32'h55 : 32'h0);
    end
    rdc("update flag", TSE_STATUS_OFS, 32'h1, 32'h1);
    rdc("presc kept", TSE_PRESC_OFS, 32'hffff, 32'h5);
    wr(TSE_STATUS_OFS, 32'h1);
    rdc("one keeps", TSE_STATUS_OFS, 32'h1, 32'h1);
    wr(TSE_STATUS_OFS, 32'h0);
    rdc("zero clears", TSE_STATUS_OFS, 32'h1, 32'h0);
    $display("force update test done");
    wr(TSE_CTRL_OFS, 32'h2);
    wr(TSE_EVGEN_OFS, 32'h1);
    pulse(1'b0, 1'b1);
    rdc("inhibit", TSE_STATUS_OFS, 32'h1, 32'h0);
    wr(TSE_ENABLE_OFS, 32'h101);
    wr(TSE_CTRL_OFS, 32'h4);
    i = udma_n;
    wr(TSE_EVGEN_OFS, 32'h1);
    pulse(1'b0, 1'b1);
    check("srcsel req", {31'h0, update_irq_req}, 32'h0);
    check("srcsel dma", 32'(udma_n - i), 32'h0);
    wr(TSE_CTRL_OFS, 32'h0);
    pulse(1'b0, 1'b1);
    check("trigger req", {31'h0, update_irq_req}, 32'h1);
    check("trigger dma", 32'(udma_n - i), 32'h1);
    rdc("trigger flag", TSE_STATUS_OFS, 32'h1, 32'h1);
    wr(TSE_STATUS_OFS, 32'h0);
    repeat (3) @(posedge core_clk);
    check("cleared req", {31'h0, update_irq_req}, 32'h0);
    wr(TSE_ENABLE_OFS, 32'h0);
    $display("update source test done");
    wr(TSE_CHMODE_OFS, 32'h0);
    wr(TSE_CH1_OFS, 32'h2);
    wr(TSE_RELOAD_OFS, 32'h3);
    wr(TSE_COUNT_OFS, 32'h0);
    wr(TSE_CTRL_OFS, 32'h1);
    for (i = 0; i < 100 && update_event !== 1'b1; i++) @(posedge core_clk);
    check("overflow", {31'h0, update_event}, 32'h1);
    wr(TSE_CTRL_OFS, 32'h0);
    rdc("match flags", TSE_STATUS_OFS, 32'h3, 32'h3);
    rdc("compare value", TSE_CH1_OFS, 32'hffff, 32'h2);
    rdc("read clears", TSE_STATUS_OFS, 32'h2, 32'h0);
    wr(TSE_STATUS_OFS, 32'h0);
    wr(TSE_COUNT_OFS, 32'h1);
    wr(TSE_CTRL_OFS, 32'h11);
    for (i = 0; i < 100 && update_event !== 1'b1; i++) @(posedge core_clk);
    check("underflow", {31'h0, update_event}, 32'h1);
    wr(TSE_CTRL_OFS, 32'h0);
    rdc("underflow flag", TSE_STATUS_OFS, 32'h1, 32'h1);
    $display("overflow compare test done");
    wr(TSE_ENABLE_OFS, 32'h202);
    wr(TSE_IRQ_MASK_OFS, 32'h2);
    rdc("irq stat clear", TSE_IRQ_STAT_OFS, 32'h7, 32'h3);
    i = dma_n;
    wr(TSE_EVGEN_OFS, 32'h2);
    repeat (4) @(posedge core_clk);
    check("forced req", {31'h0, ch1_irq_req}, 32'h1);
    check("forced dma", 32'(dma_n - i), 32'h1);
    check("irq high", {31'h0, irq}, 32'h1);
    rdc("irq stat", TSE_IRQ_STAT_OFS, 32'h2, 32'h2);
    repeat (3) @(posedge core_clk);
    check("irq read clr", {31'h0, irq}, 32'h0);
    wr(TSE_STATUS_OFS, 32'h0);
    wr(TSE_IRQ_MASK_OFS, 32'h0);
    wr(TSE_EVGEN_OFS, 32'h2);
    repeat (4) @(posedge core_clk);
    check("irq masked", {31'h0, irq}, 32'h0);
    rdc("forced flag", TSE_STATUS_OFS, 32'h202, 32'h2);
    $display("forced output test done");
    wr(TSE_CHMODE_OFS, 32'h1);
    wr(TSE_STATUS_OFS, 32'h0);
    wr(TSE_COUNT_OFS, 32'h42);
    pulse(1'b1, 1'b0);
    rdc("capture flag", TSE_STATUS_OFS, 32'h202, 32'h2);
    pulse(1'b1, 1'b0);
    rdc("overcapture", TSE_STATUS_OFS, 32'h202, 32'h202);
    rdc("captured", TSE_CH1_OFS, 32'hffff, 32'h42);
    rdc("ovc stays", TSE_STATUS_OFS, 32'h202, 32'h200);
    wr(TSE_STATUS_OFS, 32'h0);
    rdc("ovc cleared", TSE_STATUS_OFS, 32'h202, 32'h0);
    wr(TSE_COUNT_OFS, 32'h99);
    wr(TSE_EVGEN_OFS, 32'h2);
    wr(TSE_EVGEN_OFS, 32'h2);
    rdc("forced capture", TSE_STATUS_OFS, 32'h202, 32'h202);
    rdc("forced value", TSE_CH1_OFS, 32'hffff, 32'h99);
    $display("input capture test done");
    results;
  end
endmodule

bind tse_timer_status tse_props u_props (.core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .capture_pulse(capture_pulse), .trigger_reinit(trigger_reinit),
  .counter_value(counter_value), .update_event(update_event),
  .update_irq_req(update_irq_req), .ch1_irq_req(ch1_irq_req),
  .update_dma_req(update_dma_req), .ch1_dma_req(ch1_dma_req), .irq(irq));

`default_nettype wire

// ==== test/tse_props.sv ====
`timescale 1ns/1ps
`default_nettype none

module tse_props
  import tse_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        capture_pulse,
  input wire logic        trigger_reinit,
  input wire logic [15:0] counter_value,
  input wire logic        update_event,
  input wire logic        update_irq_req,
  input wire logic        ch1_irq_req,
  input wire logic        update_dma_req,
  input wire logic        ch1_dma_req,
  input wire logic        irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // ---------------------------------------------------------------
  // Accepted transfers
  // ---------------------------------------------------------------
  wire logic acc;
  wire logic rd_st;
  wire logic rd_eg;
  assign acc   = hsel & htrans[1] & hready & hreadyout;
  assign rd_st = acc & ~hwrite & (haddr[7:0] == TSE_STATUS_OFS);
  assign rd_eg = acc & ~hwrite & (haddr[7:0] == TSE_EVGEN_OFS);

  // Four cycles of look-back cover the read wait and the request register stage.
  a_write_no_wait: assert property (acc && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  a_read_one_wait: assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_evgen_reads_zero: assert property (rd_eg |=> ##1 hrdata == 32'h0)
    else $error("event generate register read nonzero");
  a_status_rsvd_zero: assert property (rd_st |=> ##1 (hrdata & 32'hffff_fdfc) == 32'h0)
    else $error("reserved status bits nonzero");
  a_ch1_flag_sticky: assert property ($fell(ch1_irq_req) |->
    $past(acc, 1) || $past(acc, 2) || $past(acc, 3) || $past(acc, 4))
    else $error("channel request fell without bus access");
  a_upd_flag_sticky: assert property ($fell(update_irq_req) |->
    $past(acc, 1) || $past(acc, 2) || $past(acc, 3) || $past(acc, 4))
    else $error("update request fell without bus access");
  a_irq_sticky: assert property ($fell(irq) |->
    $past(acc, 1) || $past(acc, 2) || $past(acc, 3) || $past(acc, 4))
    else $error("interrupt fell without bus access");
  a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> hreadyout && !irq &&
    !update_event && !ch1_dma_req && !update_dma_req && !update_irq_req && !ch1_irq_req &&
    !hresp && counter_value == 16'h0 && hrdata == 32'h0)
    else $error("outputs not quiet in reset");
endmodule

`default_nettype wire
